// file: hdl/scr_readout.sv
`include "scr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// word buffer
// ----------------------------------------
module scr_fifo #(
  parameter int WIDTH = `SCR_DATA_W,
  parameter int DEPTH = `SCR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = cnt_reg != (PW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end else begin
      if (push) begin
        mem_next[wr_reg] = in_data;
        wr_next = wr_reg + 1'b1;
      end
      if (pop) begin
        rd_next = rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule

// ----------------------------------------
// read-out core
// ----------------------------------------
module scr_readout #(
  parameter bit BIG_PART = 1'b1,
  parameter int DATA_W = `SCR_DATA_W,
  parameter int DEPTH = `SCR_FIFO_DEPTH,
  parameter int POR_CYC = `SCR_POR_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic reset_oe,
  input wire logic page_enable,
  input wire logic [1:0] page_select,
  input wire logic serial_program_enable_n,
  input wire logic program_device_select,
  output logic data_out,
  output logic data_oe_n,
  output logic cascade_out_n,
  output logic ready_out,
  output logic ready_oe_n,
  output logic prog_mode,
  output logic prog_select,
  output logic mem_rd_en,
  output logic [18-$clog2(DATA_W):0] mem_addr,
  input wire logic [DATA_W-1:0] mem_rdata
);
  localparam int AW = 19;
  localparam int SH = $clog2(DATA_W);
  localparam int WW = AW - SH;
  localparam logic [AW-1:0] FULL = BIG_PART ? `SCR_MAX_8M : `SCR_MAX_4M;
  localparam logic [AW-1:0] SPAN = BIG_PART ? `SCR_SPAN_8M : `SCR_SPAN_4M;
  localparam logic [AW-1:0] PAGE = BIG_PART ? `SCR_PAGE_8M : `SCR_PAGE_4M;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] pins, sync1_reg, sync2_reg;
  logic sclk_prev_reg;
  logic sclk_s, cs_s, oe_s, pe_s, prg_s, pds_s;
  logic [1:0] ps_s;

  assign pins = {program_device_select, serial_program_enable_n, page_select,
                 page_enable, reset_oe, chip_select_n, serial_clock};
  assign sclk_s = sync2_reg[0];
  assign cs_s = sync2_reg[1];
  assign oe_s = sync2_reg[2];
  assign pe_s = sync2_reg[3];
  assign ps_s = sync2_reg[5:4];
  assign prg_s = !sync2_reg[6];
  assign pds_s = sync2_reg[7];

  always_ff @(posedge sys_clk) begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
    sclk_prev_reg <= sclk_s;
  end

  // ----------------------------------------
  // range decode
  // ----------------------------------------
  logic paged;
  logic [AW-1:0] pg, base_w, max_w;

  always_comb begin
    paged = pe_s && !prg_s;
    pg = paged ? {17'h0, ps_s} : '0;
    base_w = AW'(pg * PAGE);
    max_w = paged ? base_w + SPAN : FULL;
  end

  // ----------------------------------------
  // control state
  // ----------------------------------------
  scr_pkg::scr_state_t state_reg, state_next;
  logic [15:0] por_reg, por_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [SH-1:0] bit_reg, bit_next;
  logic [DATA_W-1:0] word_reg, word_next;
  logic wvalid_reg, wvalid_next, done_reg, done_next;
  logic [WW-1:0] faddr_reg, faddr_next;
  logic fdone_reg, fdone_next, pend_reg, pend_next;
  logic dout_reg, dout_next, doe_n_reg, doe_n_next;
  logic casc_reg, casc_next, rdy_reg, rdy_next;
  logic pmode_reg, pmode_next, psel_reg, psel_next;
  logic clear, active, step, issue;
  logic f_in_ready, f_out_valid, f_pop;
  logic [DATA_W-1:0] f_out_data;

  assign clear = (state_reg != scr_pkg::SCR_ST_READ) || !oe_s;
  assign active = (state_reg == scr_pkg::SCR_ST_READ) && oe_s && !cs_s;
  assign step = active && !done_reg && wvalid_reg && sclk_s && !sclk_prev_reg;
  assign issue = !clear && !fdone_reg && !pend_reg && f_in_ready;
  // reload in the cycle of the last bit so the driver does not gap between words while the buffer holds the next one
  assign f_pop = (!wvalid_reg || (step && bit_reg == SH'(DATA_W - 1))) && !clear;

  always_comb begin
    state_next = state_reg;
    por_next = por_reg;
    case (state_reg)
      scr_pkg::SCR_ST_POR: begin
        por_next = por_reg + 16'h0001;
        if (por_reg == 16'(POR_CYC - 1)) begin
          state_next = prg_s ? scr_pkg::SCR_ST_PROG : scr_pkg::SCR_ST_READ;
        end
      end
      scr_pkg::SCR_ST_READ: begin
        if (prg_s) begin
          state_next = scr_pkg::SCR_ST_PROG;
        end
      end
      scr_pkg::SCR_ST_PROG: begin
        if (!prg_s) begin
          state_next = scr_pkg::SCR_ST_READ;
        end
      end
      default: begin
        state_next = scr_pkg::SCR_ST_POR;
        por_next = '0;
      end
    endcase
  end

  always_comb begin
    addr_next = addr_reg;
    bit_next = bit_reg;
    word_next = word_reg;
    wvalid_next = wvalid_reg;
    done_next = done_reg;
    faddr_next = faddr_reg;
    fdone_next = fdone_reg;
    pend_next = issue;
    if (clear) begin
      addr_next = base_w;
      bit_next = '0;
      wvalid_next = 1'b0;
      done_next = 1'b0;
      faddr_next = base_w[AW-1:SH];
      fdone_next = 1'b0;
      pend_next = 1'b0;
    end else begin
      if (issue) begin
        if (faddr_reg == max_w[AW-1:SH]) begin
          fdone_next = 1'b1;
        end else begin
          faddr_next = faddr_reg + 1'b1;
        end
      end
      if (f_pop && f_out_valid) begin
        word_next = f_out_data;
        wvalid_next = 1'b1;
      end
      if (step) begin
        if (addr_reg == max_w) begin
          done_next = 1'b1;
        end else begin
          addr_next = addr_reg + 1'b1;
        end
        bit_next = bit_reg + 1'b1;
        if (bit_reg == SH'(DATA_W - 1) && !f_out_valid) begin
          wvalid_next = 1'b0;
        end
      end
    end
  end

  always_comb begin
    dout_next = word_next[SH'(DATA_W - 1) - bit_next];
    doe_n_next = !(active && !done_next && wvalid_next);
    casc_next = !(done_next && oe_s && (state_reg == scr_pkg::SCR_ST_READ)) || cs_s;
    rdy_next = state_next != scr_pkg::SCR_ST_POR;
    pmode_next = prg_s;
    psel_next = prg_s && pds_s;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= scr_pkg::SCR_ST_POR;
      por_reg <= '0;
      addr_reg <= '0;
      bit_reg <= '0;
      word_reg <= '0;
      wvalid_reg <= 1'b0;
      done_reg <= 1'b0;
      faddr_reg <= '0;
      fdone_reg <= 1'b0;
      pend_reg <= 1'b0;
      dout_reg <= 1'b0;
      doe_n_reg <= 1'b1;
      casc_reg <= 1'b1;
      rdy_reg <= 1'b0;
      pmode_reg <= 1'b0;
      psel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      por_reg <= por_next;
      addr_reg <= addr_next;
      bit_reg <= bit_next;
      word_reg <= word_next;
      wvalid_reg <= wvalid_next;
      done_reg <= done_next;
      faddr_reg <= faddr_next;
      fdone_reg <= fdone_next;
      pend_reg <= pend_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      casc_reg <= casc_next;
      rdy_reg <= rdy_next;
      pmode_reg <= pmode_next;
      psel_reg <= psel_next;
    end
  end

  scr_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .flush(clear),
    .in_valid(pend_reg),
    .in_ready(f_in_ready),
    .in_data(mem_rdata),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  assign data_out = dout_reg;
  assign data_oe_n = doe_n_reg;
  assign cascade_out_n = casc_reg;
  assign ready_out = 1'b0;
  assign ready_oe_n = rdy_reg;
  assign prog_mode = pmode_reg;
  assign prog_select = psel_reg;
  assign mem_rd_en = issue;
  assign mem_addr = faddr_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_casc_end_low: assert property (
    step && addr_reg == max_w && oe_s ##1 oe_s && !cs_s |=> !cascade_out_n)
    else $error("cascade not low at range end");
  a_casc_oe_high: assert property (
    !oe_s |=> cascade_out_n && !done_reg)
    else $error("cascade low with enable low");
  a_casc_follow: assert property (
    done_reg && oe_s && state_reg == scr_pkg::SCR_ST_READ |=> cascade_out_n == $past(cs_s))
    else $error("cascade not following chip select");
  a_page_range: assert property (
    paged |-> base_w == (BIG_PART ? {ps_s, 17'h00000} : {1'b0, ps_s, 16'h0000})
      && max_w == (base_w | SPAN))
    else $error("page range wrong");
  a_full_range: assert property (
    !paged |-> base_w == '0 && max_w == FULL)
    else $error("full range wrong");
  a_oe_clear: assert property (
    !oe_s |=> addr_reg == $past(base_w) && data_oe_n)
    else $error("enable low did not clear");
  a_cs_standby: assert property (
    cs_s && oe_s && state_reg == scr_pkg::SCR_ST_READ |=> data_oe_n && addr_reg == $past(addr_reg))
    else $error("counting while deselected");
  a_end_float: assert property (
    done_reg |-> data_oe_n)
    else $error("driving data after last bit");
  a_step_next: assert property (
    step && addr_reg != max_w |=> addr_reg == $past(addr_reg) + 19'h00001)
    else $error("counter did not step");
  a_ready_por: assert property (
    state_reg == scr_pkg::SCR_ST_POR |=> !ready_oe_n || $past(por_reg) == 16'(POR_CYC - 1))
    else $error("ready released early");
  a_prog_sel: assert property (
    prg_s ##1 prg_s |=> prog_select == $past(pds_s) && prog_mode)
    else $error("program select not passed");
endmodule

`default_nettype wire

// file: hdl/scr_regs.svh
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH
`define SCR_MAX_4M 19'h3FFFF
`define SCR_MAX_8M 19'h7FFFF
`define SCR_SPAN_4M 19'h0FFFF
`define SCR_SPAN_8M 19'h1FFFF
`define SCR_PAGE_4M 19'h10000
`define SCR_PAGE_8M 19'h20000
`define SCR_CLK_NS 8
`define SCR_POR_NS 200
`define SCR_POR_CYC ((`SCR_POR_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_DATA_W 8
`define SCR_FIFO_DEPTH 4
`endif

// file: hdl/scr_pkg.sv
package scr_pkg;
  typedef enum logic [2:0] {
    SCR_ST_POR = 3'h1,
    SCR_ST_READ = 3'h2,
    SCR_ST_PROG = 3'h4
  } scr_state_t;
endpackage

// file: dv/scr_fpga_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// master serial far side
// ----------------------------------------
module scr_fpga_model (
  input wire logic data_out,
  input wire logic data_oe_n,
  output logic serial_clock
);
  logic bits[$];

  initial serial_clock = 1'b0;

  // clock runs only while clocks() is called, whether or not the part is selected, idles low
  task automatic clocks(input int n);
    repeat (n) begin
      #62.5;
      // a released line rests at its pull-up level
      bits.push_back(data_oe_n ? 1'b1 : data_out);
      serial_clock = 1'b1;
      #62.5;
      serial_clock = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: dv/serial_config_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.svh"

module serial_config_readout_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic chip_select_n = 1'b1;
  logic reset_oe = 1'b0;
  logic page_enable = 1'b0;
  logic [1:0] page_select = 2'h0;
  logic serial_program_enable_n = 1'b1;
  logic program_device_select = 1'b0;
  logic [7:0] mem_rdata;
  wire logic serial_clock, data_out, data_oe_n, cascade_out_n, ready_out, ready_oe_n;
  wire logic prog_mode, prog_select, mem_rd_en;
  wire logic [15:0] mem_addr;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 17;
  int p, k;
  int n_rd, rd0;
  logic [7:0] w;
  logic [15:0] base;

  always #4 sys_clk = ~sys_clk;

  scr_readout #(.BIG_PART(1'b1), .POR_CYC(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .reset_oe(reset_oe),
    .page_enable(page_enable), .page_select(page_select),
    .serial_program_enable_n(serial_program_enable_n), .program_device_select(program_device_select),
    .data_out(data_out), .data_oe_n(data_oe_n), .cascade_out_n(cascade_out_n), .ready_out(ready_out),
    .ready_oe_n(ready_oe_n), .prog_mode(prog_mode), .prog_select(prog_select), .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  scr_fpga_model fpga (.data_out(data_out), .data_oe_n(data_oe_n), .serial_clock(serial_clock));

  // ----------------------------------------
  // stored array model
  // ----------------------------------------
  function automatic logic [7:0] wd(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (mem_rd_en) begin
      mem_rdata <= wd(mem_addr);
      n_rd <= n_rd + 1;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkw(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    #1;
    chk1(ready_oe_n, 1'b0);
    chk1(ready_out, 1'b0);
    cyc(2);
    #1;
    chk1(ready_oe_n, 1'b0);
    cyc(12);
    #1;
    chk1(ready_oe_n, 1'b1);
    for (p = 0; p < 5; p++) begin
      cyc(1);
      page_enable <= (p < 4);
      page_select <= (p < 4) ? p[1:0] : 2'($random(seed));
      reset_oe <= 1'b0;
      cyc(6);
      #1;
      chk1(data_oe_n, 1'b1);
      rd0 = n_rd;
      cyc(1);
      chip_select_n <= 1'b1;
      reset_oe <= 1'b1;
      cyc(30);
      #1;
      chk1(data_oe_n, 1'b1);
      // prefetch stops once the word buffer is full
      chkw(8'(n_rd - rd0), 8'(`SCR_FIFO_DEPTH + 1));
      fpga.clocks(3);
      cyc(1);
      chip_select_n <= 1'b0;
      cyc(12);
      #1;
      chk1(data_oe_n, 1'b0);
      fpga.bits.delete();
      // six words, so the buffer pointers wrap
      fpga.clocks(48);
      base = (p < 4) ? {p[1:0], 14'h0000} : 16'h0000;
      for (k = 0; k < 48; k++) begin
        w = wd(base + 16'(k / 8));
        chk1(fpga.bits[k], w[7 - k % 8]);
      end
      chk1(cascade_out_n, 1'b1);
    end
    cyc(1);
    program_device_select <= 1'($random(seed));
    serial_program_enable_n <= 1'b0;
    cyc(6);
    #1;
    chk1(prog_mode, 1'b1);
    chk1(prog_select, program_device_select);
    cyc(1);
    serial_program_enable_n <= 1'b1;
    // second reset in mid-run, selected and enabled
    cyc(4);
    rst_b <= 1'b0;
    cyc(8);
    #1;
    chk1(ready_oe_n, 1'b0);
    chk1(data_oe_n, 1'b1);
    cyc(1);
    rst_b <= 1'b1;
    cyc(24);
    #1;
    chk1(ready_oe_n, 1'b1);
    chk1(data_oe_n, 1'b0);
    fpga.bits.delete();
    fpga.clocks(8);
    w = wd(16'h0000);
    for (k = 0; k < 8; k++) begin
      chk1(fpga.bits[k], w[7 - k]);
    end
    end_sim();
  end
endmodule

`default_nettype wire
